//--- src/wdw_pkg.sv
//----------------------------------------------------------------------
// Purpose : constants and types of the watchdog with watch mode
// Assumes : byte-wide special function register access
// Notes   : offsets are register addresses on the special function bus
//----------------------------------------------------------------------
`default_nettype none
package wdw_pkg;

    //------------------------------------------------------------------
    // register addresses
    //------------------------------------------------------------------
    localparam logic [7:0] ADDR_CLK_CTRL3  = 8'h41;
    localparam logic [7:0] ADDR_SYSFLAG_IE = 8'h8E;
    localparam logic [7:0] ADDR_PWR_FLAGS  = 8'h97;
    localparam logic [7:0] ADDR_WDOG_CTRL  = 8'hE1;

    //------------------------------------------------------------------
    // field positions and reset values
    //------------------------------------------------------------------
    localparam int WC_RST_EN    = 7;
    localparam int WC_NON_STOP  = 6;
    localparam int WC_ENABLE    = 5;
    localparam int WC_CLEAR     = 4;
    localparam int WC_IDLE      = 3;
    localparam int WC_PS_MSB    = 2;
    localparam int CK3_CS_MSB   = 7;
    localparam int CK3_CS_LSB   = 6;
    localparam int CK3_FS       = 4;
    localparam int CK3_MCKD_MSB = 3;
    localparam int CK3_MCKD_LSB = 2;
    localparam int PF_OVF       = 0;
    localparam int SYSTEM_FLAG_IRQ_ENABLE_OVF     = 0;

    localparam logic [1:0] CK3_LOW_FIXED = 2'h2;
    localparam logic [1:0] CK3_CS_RESET  = 2'h0;
    localparam logic [2:0] WC_PS_RESET   = 3'h0;

    //------------------------------------------------------------------
    // timing
    //------------------------------------------------------------------
    localparam logic [3:0] SYS_DIV        = 4'hC;
    localparam int         CLK_PERIOD_NS  = 40;
    localparam int         LRC_LATENCY_US = 120;
    localparam int         LRC_LATENCY_CYC = (LRC_LATENCY_US * 1000) / CLK_PERIOD_NS;

    //------------------------------------------------------------------
    // types
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        WDW_SRC_LRC    = 2'b00,
        WDW_SRC_EXT    = 2'b01,
        WDW_SRC_SYS12  = 2'b10,
        WDW_SRC_SERIAL = 2'b11
    } wdw_src_e;

    typedef enum logic {
        WDW_ST_LOAD = 1'b0,
        WDW_ST_RUN  = 1'b1
    } wdw_state_e;

endpackage
`default_nettype wire

//--- src/wdw_watchdog.sv
//----------------------------------------------------------------------
// Purpose : watchdog timer with watch mode, fused options, register access
// Assumes : clock source ticks, power modes and fuses synchronous to CLK
// Notes   : RST_B is power-on reset; SYS_RST covers pin, soft, wdog reset
//----------------------------------------------------------------------
// Function
// - non-stop bit keeps low-speed rc oscillator running in power-down
// - overflow in watch mode wakes cpu via interrupt or reset
// - watch wake-up only with low-speed rc or external clock source
// - reset-enable set gives system reset, else flag only
// - sticky enable bits accept only ones outside the protected page
// - non-stop clear halts in power-down; set counts in idle, and in power-down on rc or external source
// - enable bit starts watchdog; cleared only by power-on or protected page
// - clear bit write of one zeroes counter and restarts counting
// - in idle count only when idle-control bit or non-stop bit is one
// - prescaler select gives ratios 2 to 256
// - overflow source is bit-8 overflow or bit-0 overflow
// - clock source field picks rc, external pin, sysclk/12, serial overflow
// - hardware sets overflow flag, writing one clears it
// - flag interrupt enable gates the shared system-flag request
// - auto-enable fuse sets enable and loads fused fields at power-up
// - without auto-enable fuse watchdog stays off until software enables
// - auto-enable plus write-protect blocks all writes except clear
// - write-protect fuse blocks writes to reset, non-stop, idle, prescaler
// - low-speed rc path adds about 120us latency to the period
// - control register survives every reset except power-on
// - eight-bit counter behind eight-bit prescaler on selected clock
// - interrupt needs flag enable and global system-flag enable
`timescale 1ns/1ns
`default_nettype none
module wdw_watchdog
#(
    parameter int PRE_W = 8,
    parameter int CNT_W = 8
)
(
    input  wire logic                CLK,
    input  wire logic                RST_B,
    input  wire logic                SYS_RST,
    input  wire logic [7:0]          SFR_ADDR,
    input  wire logic [7:0]          SFR_WDATA,
    input  wire logic                SFR_WR,
    input  wire logic                SFR_RD,
    input  wire logic                SFR_PAGE_P,
    output logic      [7:0]          SFR_RDATA,
    input  wire logic                IDLE_MODE,
    input  wire logic                POWER_DOWN,
    input  wire logic                LRC_TICK,
    input  wire logic                EXT_CLK_TICK,
    input  wire logic                SERIAL_TIMER_OVF,
    input  wire logic                GLOBAL_SYSFLAG_IRQ_EN,
    input  wire logic                FUSE_AUTO_ENABLE,
    input  wire logic                FUSE_WRITE_PROTECT,
    input  wire logic                FUSE_RESET_ENABLE,
    input  wire logic                FUSE_NON_STOP,
    input  wire logic                FUSE_IDLE_CONTROL,
    input  wire logic [2:0]          FUSE_PRESCALER,
    output logic                     LRC_KEEP_RUNNING,
    output logic                     OVF_IRQ,
    output logic                     WDT_RESET_REQ,
    output logic                     WAKE_REQ
);
    import wdw_pkg::*;

    if (PRE_W < 8 || CNT_W < 2)
    begin : g_bad_width
        $error("prescaler needs at least 8 bits and counter at least 2");
    end

    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------
    function automatic logic sticky_bit(input logic old_v, input logic new_v,
                                        input logic page_p);
        return page_p ? new_v : (old_v | new_v);
    endfunction

    function automatic logic [PRE_W-1:0] pre_mask(input logic [2:0] ps);
        logic [PRE_W:0] t;
        t = {{PRE_W-1{1'b0}}, 2'b10} << ps;
        return PRE_W'(t - 1'b1);
    endfunction

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    wdw_state_e       state_q;
    logic             rst_en_q, non_stop_q, enable_q, idle_ctl_q;
    logic [2:0]       ps_q;
    logic [1:0]       cs_q, mckd_q;
    logic             fs_q, ie_q, flag_q, fuse_auto_q, fuse_wp_q;
    logic [3:0]       div_q;
    logic [PRE_W-1:0] pre_q;
    logic [CNT_W-1:0] cnt_q;
    logic [7:0]       rdata_q;
    logic             rst_req_q, wake_q, irq_q, lrc_run_q;

    //------------------------------------------------------------------
    // write decode
    //------------------------------------------------------------------
    wire   running   = (state_q == WDW_ST_RUN);
    wire   wr_wd     = SFR_WR && running && (SFR_ADDR == ADDR_WDOG_CTRL);
    wire   wr_ck3    = SFR_WR && SFR_PAGE_P && (SFR_ADDR == ADDR_CLK_CTRL3);
    wire   wr_pf     = SFR_WR && (SFR_ADDR == ADDR_PWR_FLAGS);
    wire   wr_ie     = SFR_WR && (SFR_ADDR == ADDR_SYSFLAG_IE);
    wire   lock_all  = fuse_auto_q && fuse_wp_q;
    wire   cfg_ok    = wr_wd && !fuse_wp_q;
    wire   en_ok     = wr_wd && !lock_all;
    wire   clear_wr  = wr_wd && SFR_WDATA[WC_CLEAR];
    wire   flag_clr  = wr_pf && SFR_WDATA[PF_OVF];

    wire   rst_en_d  = cfg_ok ? sticky_bit(rst_en_q, SFR_WDATA[WC_RST_EN], SFR_PAGE_P)
                              : rst_en_q;
    wire   non_stop_d = cfg_ok ? sticky_bit(non_stop_q, SFR_WDATA[WC_NON_STOP], SFR_PAGE_P)
                               : non_stop_q;
    wire   enable_d  = en_ok ? sticky_bit(enable_q, SFR_WDATA[WC_ENABLE], SFR_PAGE_P)
                             : enable_q;
    wire   idle_d    = cfg_ok ? SFR_WDATA[WC_IDLE] : idle_ctl_q;
    wire [2:0] ps_d  = cfg_ok ? SFR_WDATA[WC_PS_MSB:0] : ps_q;

    //------------------------------------------------------------------
    // clock source and gating
    //------------------------------------------------------------------
    wire   sys12_tick = (div_q == SYS_DIV - 4'h1);
    // low-speed rc ticks carry the oscillator's own latency upstream
    wire   src_tick  = (cs_q == WDW_SRC_LRC)   ? LRC_TICK
                     : (cs_q == WDW_SRC_EXT)   ? EXT_CLK_TICK
                     : (cs_q == WDW_SRC_SYS12) ? sys12_tick
                     : SERIAL_TIMER_OVF;
    wire   pd_src_ok = (cs_q == WDW_SRC_LRC) || (cs_q == WDW_SRC_EXT);
    wire   pd_ok     = non_stop_q && pd_src_ok;
    wire   idle_ok   = idle_ctl_q || non_stop_q;
    wire   mode_ok   = POWER_DOWN ? pd_ok : (IDLE_MODE ? idle_ok : 1'b1);
    wire   tick      = running && enable_q && mode_ok && src_tick;
    wire [PRE_W-1:0] mask = pre_mask(ps_q);
    wire   pre_tick  = tick && ((pre_q & mask) == mask);
    wire   ovf_evt   = pre_tick && (fs_q ? cnt_q[0] : (&cnt_q));
    wire   cnt_clr   = clear_wr || SYS_RST;

    //------------------------------------------------------------------
    // read mux
    //------------------------------------------------------------------
    wire [7:0] wd_view  = {rst_en_q, non_stop_q, enable_q, 1'b0, idle_ctl_q, ps_q};
    wire [7:0] ck3_view = {cs_q, 1'b0, fs_q, mckd_q, CK3_LOW_FIXED};
    wire [7:0] rdata_d  = (SFR_ADDR == ADDR_WDOG_CTRL)  ? wd_view
                        : (SFR_ADDR == ADDR_CLK_CTRL3)  ? ck3_view
                        : (SFR_ADDR == ADDR_PWR_FLAGS)  ? {7'h00, flag_q}
                        : (SFR_ADDR == ADDR_SYSFLAG_IE) ? {7'h00, ie_q}
                        : 8'h00;

    //------------------------------------------------------------------
    // control register: power-on only, fused load on release
    //------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_q     <= WDW_ST_LOAD;
            fuse_auto_q <= 1'b0;
            fuse_wp_q   <= 1'b0;
            rst_en_q    <= 1'b0;
            non_stop_q  <= 1'b0;
            enable_q    <= 1'b0;
            idle_ctl_q  <= 1'b0;
            ps_q        <= WC_PS_RESET;
        end
        else if (!running)
        begin
            state_q     <= WDW_ST_RUN;
            fuse_auto_q <= FUSE_AUTO_ENABLE;
            fuse_wp_q   <= FUSE_WRITE_PROTECT;
            if (FUSE_AUTO_ENABLE)
            begin
                enable_q   <= 1'b1;
                rst_en_q   <= FUSE_RESET_ENABLE;
                non_stop_q <= FUSE_NON_STOP;
                idle_ctl_q <= FUSE_IDLE_CONTROL;
                ps_q       <= FUSE_PRESCALER;
            end
        end
        else
        begin
            // SYS_RST deliberately leaves these untouched
            rst_en_q   <= rst_en_d;
            non_stop_q <= non_stop_d;
            enable_q   <= enable_d;
            idle_ctl_q <= idle_d;
            ps_q       <= ps_d;
        end
    end

    //------------------------------------------------------------------
    // other registers
    //------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cs_q   <= CK3_CS_RESET;
            fs_q   <= 1'b0;
            mckd_q <= 2'h0;
            ie_q   <= 1'b0;
        end
        else
        begin
            if (wr_ck3)
            begin
                cs_q   <= SFR_WDATA[CK3_CS_MSB:CK3_CS_LSB];
                fs_q   <= SFR_WDATA[CK3_FS];
                mckd_q <= SFR_WDATA[CK3_MCKD_MSB:CK3_MCKD_LSB];
            end
            if (wr_ie)
            begin
                ie_q <= SFR_WDATA[SYSTEM_FLAG_IRQ_ENABLE_OVF];
            end
        end
    end

    //------------------------------------------------------------------
    // counting chain, flag and requests
    //------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            div_q <= 4'h0;
            pre_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            div_q <= sys12_tick ? 4'h0 : div_q + 4'h1;
            if (cnt_clr)
            begin
                pre_q <= '0;
                cnt_q <= '0;
            end
            else if (tick)
            begin
                pre_q <= pre_q + 1'b1;
                cnt_q <= pre_tick ? cnt_q + 1'b1 : cnt_q;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            flag_q    <= 1'b0;
            rst_req_q <= 1'b0;
            wake_q    <= 1'b0;
            irq_q     <= 1'b0;
            lrc_run_q <= 1'b1;
            rdata_q   <= 8'h00;
        end
        else
        begin
            flag_q    <= ovf_evt || (flag_q && !flag_clr);
            rst_req_q <= ovf_evt && rst_en_q;
            wake_q    <= ovf_evt && POWER_DOWN;
            irq_q     <= flag_q && ie_q && GLOBAL_SYSFLAG_IRQ_EN;
            lrc_run_q <= !POWER_DOWN || non_stop_q;
            if (SFR_RD)
            begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign SFR_RDATA        = rdata_q;
    assign OVF_IRQ          = irq_q;
    assign WDT_RESET_REQ    = rst_req_q;
    assign WAKE_REQ         = wake_q;
    assign LRC_KEEP_RUNNING = lrc_run_q;

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    a_flag_on_ovf:    assert property (ovf_evt |=> flag_q)
        else $error("overflow did not set flag");
    a_flag_clear:     assert property (flag_clr && !ovf_evt |=> !flag_q)
        else $error("flag not cleared by write of one");
    a_reset_request:  assert property (ovf_evt && rst_en_q |=> WDT_RESET_REQ)
        else $error("overflow with reset enable gave no reset request");
    a_no_reset_req:   assert property (!$past(ovf_evt) |-> !WDT_RESET_REQ)
        else $error("reset request without overflow");
    a_enable_sticky:  assert property (wr_wd && !SFR_PAGE_P && enable_q |=> enable_q)
        else $error("enable bit cleared outside protected page");
    a_counter_clear:  assert property (clear_wr |=> cnt_q == '0 && pre_q == '0)
        else $error("clear write did not zero the counter");
    a_pd_halt:        assert property (POWER_DOWN && !non_stop_q |-> !tick)
        else $error("counting in power-down without non-stop");
    a_idle_halt:      assert property (IDLE_MODE && !POWER_DOWN
                                       && !idle_ctl_q && !non_stop_q |-> !tick)
        else $error("counting in idle with idle control clear");
    a_watch_source:   assert property (POWER_DOWN && tick |-> !cs_q[1])
        else $error("watch mode counting on unsupported source");
    a_lock_all:       assert property (lock_all && wr_wd |=>
                                       $stable({rst_en_q, non_stop_q, enable_q, idle_ctl_q, ps_q}))
        else $error("protected control register changed");
    a_irq_gate:       assert property (OVF_IRQ |->
                                       $past(ie_q) && $past(GLOBAL_SYSFLAG_IRQ_EN))
        else $error("interrupt raised while gated off");
    a_watch_wake:     assert property (ovf_evt && POWER_DOWN |=> WAKE_REQ)
        else $error("overflow in watch mode did not wake");
    a_ovf_bit8:       assert property (ovf_evt && !fs_q |-> &cnt_q)
        else $error("bit-8 overflow before counter full");

    c_reset_ovf:  cover property (ovf_evt && rst_en_q ##1 WDT_RESET_REQ);
    c_watch_wake: cover property (POWER_DOWN && ovf_evt ##1 WAKE_REQ);
    c_page_p_off: cover property (wr_wd && SFR_PAGE_P && enable_q ##1 !enable_q);
    c_fast_ovf:   cover property (fs_q && ovf_evt);

endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose : self-checking bench for the watchdog with watch mode
// Assumes : source ticks, power modes and fuses driven at the falling edge
// Notes   : register table rows first, then hand-written counting cases
`timescale 1ns/1ns
`default_nettype none
module tb_top;
import wdw_pkg::*;
//----------------------------------------------------------------------
// signals
//----------------------------------------------------------------------
typedef struct {logic [7:0] a; logic [7:0] d; logic p; logic [7:0] e;} wdw_row_s;
localparam logic [7:0] A_WC = ADDR_WDOG_CTRL;
localparam logic [7:0] A_CK = ADDR_CLK_CTRL3;
localparam logic [7:0] A_IE = ADDR_SYSFLAG_IE;
localparam logic [7:0] A_PF = ADDR_PWR_FLAGS;
logic       clk, rst_b, sys_rst, wr_s, rd_s, page_p, idle, pd, lrc, ext, ser, gie;
logic       f_auto, f_wp, f_rst, f_ns, f_idl, keep, irq, rreq, wreq;
logic [2:0] f_ps;
logic [7:0] addr, wdata, rdata;
int         failures = 0;
int         comparisons = 0;
int         rst_cnt = 0;
int         wake_cnt = 0;
wdw_row_s   rows [10] = '{'{8'hE1, 8'h20, 1'b0, 8'h20}, '{8'hE1, 8'h00, 1'b0, 8'h20},
    '{8'hE1, 8'hC8, 1'b0, 8'hE8}, '{8'hE1, 8'h10, 1'b0, 8'hE0}, '{8'hE1, 8'h01, 1'b1, 8'h01},
    '{8'h41, 8'hC0, 1'b0, 8'h02}, '{8'h41, 8'h52, 1'b1, 8'h52}, '{8'h8E, 8'h01, 1'b0, 8'h01},
    '{8'h55, 8'hFF, 1'b0, 8'h00}, '{8'h97, 8'h01, 1'b0, 8'h00}};

wdw_watchdog i_dut (.CLK(clk), .RST_B(rst_b), .SYS_RST(sys_rst), .SFR_ADDR(addr),
    .SFR_WDATA(wdata), .SFR_WR(wr_s), .SFR_RD(rd_s), .SFR_PAGE_P(page_p), .SFR_RDATA(rdata),
    .IDLE_MODE(idle), .POWER_DOWN(pd), .LRC_TICK(lrc), .EXT_CLK_TICK(ext),
    .SERIAL_TIMER_OVF(ser), .GLOBAL_SYSFLAG_IRQ_EN(gie), .FUSE_AUTO_ENABLE(f_auto),
    .FUSE_WRITE_PROTECT(f_wp), .FUSE_RESET_ENABLE(f_rst), .FUSE_NON_STOP(f_ns),
    .FUSE_IDLE_CONTROL(f_idl), .FUSE_PRESCALER(f_ps), .LRC_KEEP_RUNNING(keep),
    .OVF_IRQ(irq), .WDT_RESET_REQ(rreq), .WAKE_REQ(wreq));
//----------------------------------------------------------------------
// clock, pulse counters, watchdog
//----------------------------------------------------------------------
initial
begin
    clk = 1'b0;
    forever #20 clk = ~clk;
end
always @(negedge clk)
begin
    if (rreq === 1'b1) rst_cnt++;
    if (wreq === 1'b1) wake_cnt++;
end
initial
begin
    repeat (60000) @(posedge clk);
    failures++;
    report_and_stop();
end
//----------------------------------------------------------------------
// tasks
//----------------------------------------------------------------------
task automatic report_and_stop();
    $display("checks %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
        failures++;
        $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
endtask
task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
        failures++;
        $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic p);
    @(negedge clk);
    addr = a;
    wdata = d;
    page_p = p;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
endtask
task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk8(rdata, e);
endtask
// source select, control byte, then flag cleared
task automatic cfg(input logic [1:0] cs, input logic fs, input logic [7:0] e);
    wr(A_CK, {cs, 1'b0, fs, 4'h2}, 1'b1);
    wr(A_WC, e, 1'b1);
    wr(A_PF, 8'h01, 1'b0);
endtask
// n ticks of source src; src 2, the divided system clock, gets n+1 ticks
task automatic tick(input int src, input int n);
    if (src == 2) repeat (12 * n + 12) @(negedge clk);
    else
    begin
        @(negedge clk);
        lrc = (src == 0);
        ext = (src == 1);
        ser = (src == 3);
        repeat (n) @(negedge clk);
        lrc = 1'b0;
        ext = 1'b0;
        ser = 1'b0;
    end
    repeat (3) @(negedge clk);
endtask
task automatic dorst(input logic [7:0] f);
    {f_auto, f_wp, f_rst, f_ns, f_idl, f_ps} = f;
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
endtask
//----------------------------------------------------------------------
// sequence
//----------------------------------------------------------------------
initial
begin
    {rst_b, sys_rst, wr_s, rd_s, page_p, idle, pd, lrc, ext, ser, gie} = '0;
    {addr, wdata} = '0;
    dorst(8'h00);
    rd(A_WC, 8'h00);
    rd(A_CK, 8'h02);
    rd(A_IE, 8'h00);
    rd(A_PF, 8'h00);
    chk1(keep, 1'b1);
    foreach (rows[i])
    begin
        wr(rows[i].a, rows[i].d, rows[i].p);
        rd(rows[i].a, rows[i].e);
    end
    for (int ps = 0; ps < 8; ps++)
    begin
        cfg(2'h0, 1'b1, 8'h30 | 8'(ps));
        tick(0, (4 << ps) - 1);
        rd(A_PF, 8'h00);
        tick(0, 1);
        rd(A_PF, 8'h01);
    end
    chk1(irq, 1'b0);
    gie = 1'b1;
    repeat (3) @(negedge clk);
    chk1(irq, 1'b1);
    wr(A_IE, 8'h00, 1'b0);
    repeat (2) @(negedge clk);
    chk1(irq, 1'b0);
    wr(A_IE, 8'h01, 1'b0);
    wr(A_PF, 8'h00, 1'b0);
    rd(A_PF, 8'h01);
    cfg(2'h0, 1'b0, 8'h30);
    tick(0, 511);
    rd(A_PF, 8'h00);
    tick(0, 1);
    rd(A_PF, 8'h01);
    for (int cs = 0; cs < 4; cs++)
    begin
        cfg(2'(cs), 1'b1, 8'h30);
        tick(cs, 4);
        rd(A_PF, 8'h01);
    end
    cfg(2'h1, 1'b1, 8'h30);
    tick(0, 4);
    rd(A_PF, 8'h00);
    chk8(8'(rst_cnt), 8'h00);
    cfg(2'h0, 1'b1, 8'hB0);
    tick(0, 4);
    chk8(8'(rst_cnt), 8'h01);
    idle = 1'b1;
    cfg(2'h0, 1'b1, 8'h30);
    tick(0, 4);
    rd(A_PF, 8'h00);
    cfg(2'h0, 1'b1, 8'h38);
    tick(0, 4);
    rd(A_PF, 8'h01);
    cfg(2'h0, 1'b1, 8'h70);
    tick(0, 4);
    rd(A_PF, 8'h01);
    idle = 1'b0;
    pd = 1'b1;
    cfg(2'h0, 1'b1, 8'h38);
    chk1(keep, 1'b0);
    tick(0, 4);
    rd(A_PF, 8'h00);
    cfg(2'h0, 1'b1, 8'h70);
    chk1(keep, 1'b1);
    tick(0, 4);
    chk8(8'(wake_cnt), 8'h01);
    cfg(2'h3, 1'b1, 8'h70);
    tick(3, 4);
    chk8(8'(wake_cnt), 8'h01);
    cfg(2'h1, 1'b1, 8'h70);
    tick(1, 4);
    chk8(8'(wake_cnt), 8'h02);
    pd = 1'b0;
    cfg(2'h0, 1'b1, 8'h30);
    tick(0, 3);
    wr(A_WC, 8'h30, 1'b0);
    tick(0, 3);
    rd(A_PF, 8'h00);
    tick(0, 1);
    rd(A_PF, 8'h01);
    wr(A_PF, 8'h01, 1'b0);
    tick(0, 3);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    tick(0, 3);
    rd(A_PF, 8'h00);
    tick(0, 1);
    rd(A_PF, 8'h01);
    rd(A_WC, 8'h20);
    rd(A_CK, 8'h12);
    dorst(8'hDD);
    rd(A_WC, 8'h6D);
    wr(A_WC, 8'h00, 1'b1);
    rd(A_WC, 8'h6D);
    dorst(8'h40);
    wr(A_CK, 8'h12, 1'b1);
    tick(0, 8);
    rd(A_PF, 8'h00);
    wr(A_WC, 8'hFF, 1'b1);
    rd(A_WC, 8'h20);
    report_and_stop();
end
endmodule
`default_nettype wire
